// ===== src/levelization_timing_register.sv
// Levelization mode and timing register with command-gated field updates
`timescale 1ns/1ps
module levelization_timing_register (
  input  wire logic                                core_clk,
  input  wire logic                                sys_rst,
  input  wire logic                                reg_wr,
  input  wire logic                                reg_rd,
  input  wire logic [level_timing_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [level_timing_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic [3:0]                          measured_delay,
  input  wire logic [2:0]                          transfer_offset,
  output logic      [level_timing_pkg::DATA_W-1:0] reg_rdata_q,
  output logic                                     level_mode_flag_q,
  output logic                                     measure_en_q,
  output logic      [3:0]                          access_delay_field_q,
  output logic      [2:0]                          expansion_read_delay_field_q,
  output logic      [2:0]                          stick_read_delay_field_q,
  output logic                                     freq_select_q,
  output logic      [2:0]                          read_delay_q
);
  import level_timing_pkg::*;

  logic       hit;
  level_cmd_t cmd;
  logic       mode_d;
  logic [3:0] acc_d;
  logic [2:0] exp_d;
  logic [2:0] stk_d;
  logic       freq_d;
  logic [3:0] exit_diff;
  logic [DATA_W-1:0] rdata_d;

  assign hit = (reg_addr == LEVEL_TIMING_OFF);
  assign cmd = level_cmd_t'(reg_wdata[CMD_HI:CMD_LO]);
  // Measured delay is larger than the access part; keep low bits of the difference
  assign exit_diff = measured_delay - access_delay_field_q;

  always_comb begin
    mode_d = level_mode_flag_q;
    acc_d  = access_delay_field_q;
    exp_d  = expansion_read_delay_field_q;
    stk_d  = stick_read_delay_field_q;
    freq_d = freq_select_q;
    if (reg_wr && hit) begin
      case (cmd)
        no_operation_code: begin
          mode_d = level_mode_flag_q;
        end
        write_access_delay_cmd: begin
          acc_d = reg_wdata[ACC_HI:ACC_LO];
        end
        write_expansion_delay_cmd: begin
          exp_d = reg_wdata[EXP_HI:EXP_LO];
        end
        write_stick_delay_cmd: begin
          if (!level_mode_flag_q) begin
            stk_d = reg_wdata[STK_HI:STK_LO];
          end
        end
        write_freq_cmd: begin
          freq_d = reg_wdata[FREQ_BIT];
        end
        write_all_cmd: begin
          acc_d  = reg_wdata[ACC_HI:ACC_LO];
          exp_d  = reg_wdata[EXP_HI:EXP_LO];
          freq_d = reg_wdata[FREQ_BIT];
          if (!level_mode_flag_q) begin
            stk_d = reg_wdata[STK_HI:STK_LO];
          end
        end
        exit_level_mode_cmd: begin
          mode_d = 1'b0;
          if (level_mode_flag_q) begin
            stk_d = exit_diff[2:0];
          end
        end
        enter_level_mode_cmd: begin
          mode_d = 1'b1;
        end
        default: begin
          mode_d = level_mode_flag_q;
        end
      endcase
    end
  end

  always_comb begin
    rdata_d = reg_rdata_q;
    if (reg_rd) begin
      if (hit) begin
        rdata_d = {level_mode_flag_q, 3'h0, access_delay_field_q, freq_select_q,
                   expansion_read_delay_field_q, 1'b0, stick_read_delay_field_q};
      end else begin
        rdata_d = 16'h0000;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      level_mode_flag_q            <= 1'b0;
      measure_en_q                 <= 1'b0;
      access_delay_field_q         <= LEVEL_TIMING_RST[ACC_HI:ACC_LO];
      expansion_read_delay_field_q <= LEVEL_TIMING_RST[EXP_HI:EXP_LO];
      stick_read_delay_field_q     <= LEVEL_TIMING_RST[STK_HI:STK_LO];
      freq_select_q                <= LEVEL_TIMING_RST[FREQ_BIT];
      reg_rdata_q                  <= LEVEL_TIMING_RST;
    end else begin
      level_mode_flag_q            <= mode_d;
      // Measuring runs exactly while the status bit is set, so both change on one edge
      measure_en_q                 <= mode_d;
      access_delay_field_q         <= acc_d;
      expansion_read_delay_field_q <= exp_d;
      stick_read_delay_field_q     <= stk_d;
      freq_select_q                <= freq_d;
      reg_rdata_q                  <= rdata_d;
    end
  end

  read_delay_select u_read_delay (
    .core_clk        (core_clk),
    .sys_rst         (sys_rst),
    .level_mode      (level_mode_flag_q),
    .exp_delay       (expansion_read_delay_field_q),
    .transfer_offset (transfer_offset),
    .read_delay_q    (read_delay_q)
  );

  // Checks
  sequence s_stick_write_norm;
    reg_wr && hit && !level_mode_flag_q && (cmd == write_stick_delay_cmd);
  endsequence

  sequence s_write_all_norm;
    reg_wr && hit && !level_mode_flag_q && (cmd == write_all_cmd);
  endsequence

  a_stick_write: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_stick_write_norm |=> stick_read_delay_field_q == $past(reg_wdata[STK_HI:STK_LO]))
    else $error("stick delay not written");
  a_stick_locked: assert property (@(posedge core_clk) disable iff (sys_rst)
    (reg_wr && hit && level_mode_flag_q && (cmd == write_stick_delay_cmd || cmd == write_all_cmd))
    |=> $stable(stick_read_delay_field_q))
    else $error("stick delay changed in levelization");
  a_access_write: assert property (@(posedge core_clk) disable iff (sys_rst)
    (reg_wr && hit && (cmd == write_access_delay_cmd || cmd == write_all_cmd))
    |=> access_delay_field_q == $past(reg_wdata[ACC_HI:ACC_LO]))
    else $error("access delay not written");
  a_nop_stable: assert property (@(posedge core_clk) disable iff (sys_rst)
    (reg_wr && hit && cmd == no_operation_code) |=> $stable(access_delay_field_q)
    && $stable(expansion_read_delay_field_q) && $stable(freq_select_q)
    && $stable(level_mode_flag_q) && $stable(stick_read_delay_field_q))
    else $error("no-operation changed a field");
  a_exp_write: assert property (@(posedge core_clk) disable iff (sys_rst)
    (reg_wr && hit && cmd == write_expansion_delay_cmd)
    |=> expansion_read_delay_field_q == $past(reg_wdata[EXP_HI:EXP_LO]))
    else $error("expansion delay not written");
  a_freq_write: assert property (@(posedge core_clk) disable iff (sys_rst)
    (reg_wr && hit && cmd == write_freq_cmd) |=> freq_select_q == $past(reg_wdata[FREQ_BIT]))
    else $error("frequency bit not written");
  a_enter_mode: assert property (@(posedge core_clk) disable iff (sys_rst)
    (reg_wr && hit && cmd == enter_level_mode_cmd) |=> level_mode_flag_q && measure_en_q)
    else $error("levelization not entered");
  a_exit_mode: assert property (@(posedge core_clk) disable iff (sys_rst)
    (reg_wr && hit && level_mode_flag_q && cmd == exit_level_mode_cmd)
    |=> !level_mode_flag_q
    && stick_read_delay_field_q == 3'($past(measured_delay) - $past(access_delay_field_q)))
    else $error("levelization exit wrong");
  a_fixed_delay: assert property (@(posedge core_clk) disable iff (sys_rst)
    (level_mode_flag_q && $stable(level_mode_flag_q) && $stable(transfer_offset))
    |=> read_delay_q == LEVEL_FIXED_DLY - $past(transfer_offset))
    else $error("levelization read delay not fixed");
  a_read_back: assert property (@(posedge core_clk) disable iff (sys_rst)
    (reg_rd && hit) |=> reg_rdata_q[MODE_BIT] == $past(level_mode_flag_q)
    && reg_rdata_q[CMD_HI:CMD_LO] == 3'h0)
    else $error("read back wrong");
  a_write_all: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_write_all_norm |=> access_delay_field_q == $past(reg_wdata[ACC_HI:ACC_LO])
    && expansion_read_delay_field_q == $past(reg_wdata[EXP_HI:EXP_LO])
    && freq_select_q == $past(reg_wdata[FREQ_BIT])
    && stick_read_delay_field_q == $past(reg_wdata[STK_HI:STK_LO]))
    else $error("write-all did not load every field");
  a_write_all_level: assert property (@(posedge core_clk) disable iff (sys_rst)
    (reg_wr && hit && level_mode_flag_q && cmd == write_all_cmd)
    |=> expansion_read_delay_field_q == $past(reg_wdata[EXP_HI:EXP_LO])
    && freq_select_q == $past(reg_wdata[FREQ_BIT]))
    else $error("write-all in levelization dropped a field");
  a_mode_steady: assert property (@(posedge core_clk) disable iff (sys_rst)
    !(reg_wr && hit && (cmd == exit_level_mode_cmd || cmd == enter_level_mode_cmd))
    |=> $stable(level_mode_flag_q))
    else $error("levelization status changed without a command");
  a_exit_clears: assert property (@(posedge core_clk) disable iff (sys_rst)
    (reg_wr && hit && cmd == exit_level_mode_cmd) |=> !level_mode_flag_q && !measure_en_q)
    else $error("levelization status not cleared");
  a_exit_normal: assert property (@(posedge core_clk) disable iff (sys_rst)
    (reg_wr && hit && !level_mode_flag_q && cmd == exit_level_mode_cmd)
    |=> $stable(stick_read_delay_field_q))
    else $error("exit outside levelization changed stick delay");
  a_normal_delay: assert property (@(posedge core_clk) disable iff (sys_rst)
    !level_mode_flag_q |=> read_delay_q == $past(expansion_read_delay_field_q))
    else $error("normal read delay does not follow expansion field");
  a_read_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    !reg_rd |=> $stable(reg_rdata_q))
    else $error("read data changed without a read");
  a_access_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    !(reg_wr && hit && (cmd == write_access_delay_cmd || cmd == write_all_cmd))
    |=> $stable(access_delay_field_q))
    else $error("access delay changed without its command");
  a_freq_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    !(reg_wr && hit && (cmd == write_freq_cmd || cmd == write_all_cmd))
    |=> $stable(freq_select_q))
    else $error("frequency bit changed without its command");
endmodule

// ===== src/level_timing_pkg.sv
// Package: offsets, field layout, commands and timing constants of the levelization register
package level_timing_pkg;
  localparam int unsigned     DATA_W           = 16;
  localparam int unsigned     ADDR_W           = 8;
  localparam logic [7:0]      LEVEL_TIMING_OFF = 8'h0e;
  localparam logic [15:0]     LEVEL_TIMING_RST = 16'h0000;
  localparam int unsigned     MODE_BIT         = 15;
  localparam int unsigned     CMD_HI           = 14;
  localparam int unsigned     CMD_LO           = 12;
  localparam int unsigned     ACC_HI           = 11;
  localparam int unsigned     ACC_LO           = 8;
  localparam int unsigned     FREQ_BIT         = 7;
  localparam int unsigned     EXP_HI           = 6;
  localparam int unsigned     EXP_LO           = 4;
  localparam int unsigned     STK_HI           = 2;
  localparam int unsigned     STK_LO           = 0;
  localparam logic [2:0]      LEVEL_FIXED_DLY  = 3'h3;
  localparam int unsigned     FREQ_LO_MHZ      = 300;
  localparam int unsigned     FREQ_HI_MHZ      = 400;

  typedef enum logic [2:0] {
    no_operation_code         = 3'b000,
    write_access_delay_cmd    = 3'b001,
    write_expansion_delay_cmd = 3'b010,
    write_stick_delay_cmd     = 3'b011,
    write_freq_cmd            = 3'b100,
    write_all_cmd             = 3'b101,
    exit_level_mode_cmd       = 3'b110,
    enter_level_mode_cmd      = 3'b111
  } level_cmd_t;
endpackage

// ===== src/read_delay_select.sv
// Read delay selector: effective stick to expansion read delay
`timescale 1ns/1ps
module read_delay_select (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       level_mode,
  input  wire logic [2:0] exp_delay,
  input  wire logic [2:0] transfer_offset,
  output logic      [2:0] read_delay_q
);
  import level_timing_pkg::*;

  logic [2:0] read_delay_d;

  always_comb begin
    if (level_mode) begin
      read_delay_d = LEVEL_FIXED_DLY - transfer_offset;
    end else begin
      read_delay_d = exp_delay;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      read_delay_q <= 3'h0;
    end else begin
      read_delay_q <= read_delay_d;
    end
  end
endmodule

// ===== bench/host_controller_model.sv
// Host controller model: register writes and reads over the hub's register port
`timescale 1ns/1ps
module host_controller_model (
  input  wire logic        core_clk,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic [7:0]       reg_addr,
  output logic [15:0]      reg_wdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
  end
  // Callers write access delay only as 4 to 9 and set frequency before interface init
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(negedge core_clk);
    reg_wr <= 1'b0;
    // Released lines show the inverse so a stale value cannot pass for a live one
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(negedge core_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
  endtask
endmodule

// ===== bench/levelization_timing_register_tb_top.sv
// Testbench: command sequences through the levelization and timing register
`timescale 1ns/1ps
module levelization_timing_register_tb_top;
  import level_timing_pkg::*;
  logic        core_clk;
  logic        sys_rst;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic [3:0]  measured_delay;
  logic [2:0]  transfer_offset;
  logic [15:0] reg_rdata_q;
  logic        meas_q;
  logic [2:0]  rdly_q;
  logic        lm_q;
  logic [3:0]  acc_q;
  logic [2:0]  exp_q;
  logic [2:0]  stk_q;
  logic        frq_q;
  int          bad_count;
  int          checks_done;

  host_controller_model host_controller_model_i (.core_clk(core_clk), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  levelization_timing_register levelization_timing_register_i (.core_clk(core_clk),
    .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .measured_delay(measured_delay),
    .transfer_offset(transfer_offset), .reg_rdata_q(reg_rdata_q), .level_mode_flag_q(lm_q),
    .measure_en_q(meas_q), .access_delay_field_q(acc_q), .expansion_read_delay_field_q(exp_q),
    .stick_read_delay_field_q(stk_q), .freq_select_q(frq_q), .read_delay_q(rdly_q));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic w(input logic [15:0] d);
    host_controller_model_i.wr(LEVEL_TIMING_OFF, d);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    host_controller_model_i.rd(a);
    check("register", reg_rdata_q, exp);
  endtask
  // Field outputs packed in register layout, so one expected word covers them all
  task automatic fchk(input logic [15:0] exp);
    check("fields", {lm_q, 3'h0, acc_q, frq_q, exp_q, 1'b0, stk_q}, exp);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // A hung run is cut short and counted as a failure
  initial begin
    #100us;
    bad_count++;
    end_sim;
  end

  initial begin
    bad_count = 0;
    checks_done = 0;
    sys_rst = 1'b1;
    measured_delay = 4'h0;
    transfer_offset = 3'h1;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    sys_rst = 1'b0;
    rchk(LEVEL_TIMING_OFF, 16'h0000);
    w(16'h1500);
    rchk(LEVEL_TIMING_OFF, 16'h0500);
    w(16'h0fff);
    rchk(LEVEL_TIMING_OFF, 16'h0500);
    w(16'h2070);
    rchk(LEVEL_TIMING_OFF, 16'h0570);
    check("read_delay", {13'h0000, rdly_q}, 16'h0007);
    w(16'h4080);
    rchk(LEVEL_TIMING_OFF, 16'h05f0);
    fchk(16'h05f0);
    w(16'h3006);
    rchk(LEVEL_TIMING_OFF, 16'h05f6);
    host_controller_model_i.wr(8'h0c, 16'h5fff);
    rchk(8'h0c, 16'h0000);
    rchk(LEVEL_TIMING_OFF, 16'h05f6);
    w(16'h7000);
    rchk(LEVEL_TIMING_OFF, 16'h85f6);
    check("measure_en", {15'h0000, meas_q}, 16'h0001);
    check("read_delay", {13'h0000, rdly_q}, 16'h0002);
    w(16'h3001);
    w(16'h2030);
    rchk(LEVEL_TIMING_OFF, 16'h85b6);
    fchk(16'h85b6);
    check("read_delay", {13'h0000, rdly_q}, 16'h0002);
    transfer_offset = 3'h0;
    measured_delay = 4'hc;
    w(16'h5912);
    rchk(LEVEL_TIMING_OFF, 16'h8916);
    check("read_delay", {13'h0000, rdly_q}, 16'h0003);
    w(16'h6000);
    rchk(LEVEL_TIMING_OFF, 16'h0913);
    fchk(16'h0913);
    check("read_delay", {13'h0000, rdly_q}, 16'h0001);
    w(16'h5485);
    rchk(LEVEL_TIMING_OFF, 16'h0485);
    w(16'h6000);
    rchk(LEVEL_TIMING_OFF, 16'h0485);
    w(16'h7000);
    rchk(LEVEL_TIMING_OFF, 16'h8485);
    check("read_delay", {13'h0000, rdly_q}, 16'h0003);
    // Reset in mid-run must drop levelization and every field at once
    @(negedge core_clk);
    sys_rst = 1'b1;
    repeat (2) @(negedge core_clk);
    sys_rst = 1'b0;
    check("rdata_reset", reg_rdata_q, 16'h0000);
    fchk(16'h0000);
    check("measure_en", {15'h0000, meas_q}, 16'h0000);
    check("read_delay", {13'h0000, rdly_q}, 16'h0000);
    rchk(LEVEL_TIMING_OFF, 16'h0000);
    end_sim;
  end
endmodule
